// [hdl/rbpm_pkg.sv]
package rbpm_pkg;

	// Last machine cycle divider count; one machine cycle is this count plus one oscillator clocks
	localparam logic [3:0]  MC_LAST         = 4'hB;
	// Machine cycles the reset pin must stay high before a reset is taken
	localparam logic [1:0]  RESET_MIN_MC    = 2'h2;
	// Clocks a wake pin must stay low before power-down is left
	localparam logic [10:0] WAKE_LOW_CLOCKS = 11'h400;

	// Register byte offsets, one aligned word each
	localparam logic [3:0]  OFS_POWER_CONTROL = 4'h0;
	localparam logic [3:0]  OFS_FLASH_CONFIG  = 4'h4;
	localparam logic [3:0]  OFS_BOOT_VECTOR   = 4'h8;
	localparam logic [3:0]  OFS_STATUS        = 4'hC;

	// Field positions in power_control_reg
	localparam int          IDLE_POS      = 0;
	localparam int          PD_POS        = 1;
	localparam int          POF_POS       = 4;
	// Field positions in flash_config_reg
	localparam int          STRAP_POS     = 0;
	localparam int          USER_VEC_POS  = 2;
	localparam int          FROM_ZERO_POS = 3;
	// Field positions in the status word
	localparam int          CORE_RST_POS  = 3;
	localparam int          ADDR_POS      = 16;

	// Reset values of the stored boot controls
	localparam logic        USER_VEC_RST    = 1'b1;
	localparam logic        FROM_ZERO_RST   = 1'b1;
	localparam logic [7:0]  BOOT_VECTOR_RST = 8'h00;
	localparam logic [15:0] ZERO_ADDR       = 16'h0000;
	// Address masks for the user vector: top two or top three bits cleared
	localparam logic [15:0] LARGE_MASK      = 16'h3FFF;
	localparam logic [15:0] SMALL_MASK      = 16'h1FFF;

	// Sequencer modes
	typedef enum logic [2:0] {
		MODE_RESET,
		MODE_RUN,
		MODE_IDLE,
		MODE_PDOWN,
		MODE_WAKE
	} mode_t;

	// Avalon-MM request from the master
	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} avs_req_t;

	// Pins arriving from outside the clock domain
	typedef struct packed {
		logic int1_n;
		logic int0_n;
		logic p1_1;
		logic p1_0;
		logic ea_n;
		logic rst_pin;
	} pins_t;

endpackage : rbpm_pkg

// [hdl/pin_filter.sv]
`timescale 1ns/10ps
// Three-stage synchroniser; a level counts once stages two and three agree
module pin_filter #(
	parameter int WIDTH = 6
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pin_in,
	output      logic [WIDTH-1:0] level
);

	// Whole state of the filter
	typedef struct packed {
		logic [WIDTH-1:0] s1;   // First stage, read only by s2
		logic [WIDTH-1:0] s2;   // Second stage
		logic [WIDTH-1:0] s3;   // Third stage
		logic [WIDTH-1:0] lvl;  // Accepted level
	} filt_t;

	filt_t q;
	filt_t d;

	// Next state: shift, and accept a level per bit on agreement
	always_comb begin
		d    = q;
		d.s1 = pin_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < WIDTH; i++) begin
			// Disagreement means the pin is still moving; keep old level
			if (q.s2[i] == q.s3[i]) begin
				d.lvl[i] = q.s3[i];
			end
		end
	end

	// Registers; all stages clear, real levels settle four clocks later
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{s1: '0, s2: '0, s3: '0, lvl: '0};
		end else begin
			q <= d;
		end
	end

	assign level = q.lvl;

endmodule : pin_filter

// [hdl/reset_boot_power_modes.sv]
`timescale 1ns/10ps
module reset_boot_power_modes #(
	parameter logic        LARGE_PART        = 1'b1,     // Selects which top address bits clear
	parameter logic [15:0] DEFAULT_BOOT_ADDR = 16'h2000  // Default boot vector, plain value
) (
	input  wire logic                clk,
	input  wire logic                rst,
	// Register bus
	input  wire rbpm_pkg::avs_req_t  avs_req,
	output      logic [31:0]         avs_readdata,
	output      logic                avs_waitrequest,
	// Pins from outside the clock domain
	input  wire rbpm_pkg::pins_t     pins,
	// Core side, same clock
	input  wire logic                core_ale,
	input  wire logic                core_program_store_strobe_n_n,
	input  wire logic                irq_start,
	input  wire logic                int0_enable,
	input  wire logic                int1_enable,
	// Outputs
	output      logic                core_reset,
	output      logic                cpu_run,
	output      logic                clock_run,
	output      logic [15:0]         boot_address,
	output      logic                address_latch_strobe,
	output      logic                program_store_strobe_n,
	output      logic                strobe_weak,
	output      logic                port_pull_high,
	output      logic                wake_int,
	output      logic                wake_source
);

	// Whole state of the sequencer
	typedef struct packed {
		rbpm_pkg::mode_t mode;          // Current sequencer mode
		logic [3:0]      mc_cnt;        // Machine cycle divider
		logic [1:0]      hold_mc;       // Machine cycles reset pin seen high
		logic            pin_prev;      // Filtered reset pin, one cycle back
		logic            por_seq;       // Still in the power-up sequence
		logic [10:0]     low_cnt;       // Clocks a wake pin has been low
		logic            wake_src;      // Which external interrupt woke us
		logic            idle_bit;      // Idle request
		logic            power_down_bit; // Power-down request
		logic            power_on_flag; // Set at power-up only
		logic            strap_boot_status; // Last boot had both straps low
		logic            user_vec_n;    // Zero selects the user vector
		logic            from_zero_n;   // Zero selects address zero
		logic [7:0]      boot_vec;      // Programmable boot vector
		logic [15:0]     boot_addr;     // Start address handed to the core
		logic            core_reset;    // Core held in reset
		logic            cpu_run;       // Program counter may advance
		logic            clock_run;     // Core clock enabled
		logic            ale;           // Address latch strobe out
		logic            program_store_strobe_n_n;        // Program store strobe out
		logic            strobe_weak;   // Strobes driven weakly
		logic            port_pull;     // Ports weakly pulled high
		logic            wake_int;      // Wake interrupt start pulse
		logic            waitrequest;   // Bus wait, high when idle
		logic [31:0]     readdata;      // Bus read data
	} state_t;

	// Value taken on the power-on reset
	localparam state_t RESET_STATE = '{
		mode:              rbpm_pkg::MODE_RESET,
		mc_cnt:            4'h0,
		hold_mc:           2'h0,
		pin_prev:          1'b0,
		por_seq:           1'b1,
		low_cnt:           11'h000,
		wake_src:          1'b0,
		idle_bit:          1'b0,
		power_down_bit:    1'b0,
		power_on_flag:     1'b1,
		strap_boot_status: 1'b0,
		user_vec_n:        rbpm_pkg::USER_VEC_RST,
		from_zero_n:       rbpm_pkg::FROM_ZERO_RST,
		boot_vec:          rbpm_pkg::BOOT_VECTOR_RST,
		boot_addr:         rbpm_pkg::ZERO_ADDR,
		core_reset:        1'b1,
		cpu_run:           1'b0,
		clock_run:         1'b1,
		ale:               1'b1,
		program_store_strobe_n_n:            1'b1,
		strobe_weak:       1'b1,
		port_pull:         1'b1,
		wake_int:          1'b0,
		waitrequest:       1'b1,
		readdata:          32'h0000_0000
	};

	state_t          q;             // Registered state
	state_t          d;             // Next state
	rbpm_pkg::pins_t pin_lvl;       // Filtered pin levels

	// Every outside pin goes through the three-stage filter
	pin_filter #(
		.WIDTH  ($bits(rbpm_pkg::pins_t))
	) u_pin_filter (
		.clk    (clk),
		.rst    (rst),
		.pin_in (pins),
		.level  (pin_lvl)
	);

	// Start address chosen at the reset fall
	function automatic logic [15:0] pick_boot(
		input logic       ea_n,
		input logic       straps_low,
		input logic       user_vec_n,
		input logic       from_zero_n,
		input logic [7:0] vec
	);
		logic [15:0] user_addr;
		user_addr = {vec, 8'h00} & (LARGE_PART ? rbpm_pkg::LARGE_MASK : rbpm_pkg::SMALL_MASK);
		if (!ea_n) begin
			pick_boot = rbpm_pkg::ZERO_ADDR;
		end else if (straps_low) begin
			pick_boot = user_vec_n ? DEFAULT_BOOT_ADDR : user_addr;
		end else if (!from_zero_n) begin
			pick_boot = rbpm_pkg::ZERO_ADDR;
		end else begin
			pick_boot = user_vec_n ? DEFAULT_BOOT_ADDR : user_addr;
		end
	endfunction : pick_boot

	// Next-state logic for divider, reset qualifier, bus and modes
	always_comb begin
		logic        mc_tick;       // One clock per machine cycle
		logic        reset_ok;      // Pin high long enough to count
		logic        release_now;   // Qualified falling edge of reset
		logic        straps_low;    // Both strap pins low
		logic        wr_hit;        // Write taken this edge
		logic        wake_low;      // Enabled wake pin held low
		logic [31:0] rd;            // Read mux
		mc_tick     = 1'b0;
		reset_ok    = 1'b0;
		release_now = 1'b0;
		straps_low  = 1'b0;
		wr_hit      = 1'b0;
		wake_low    = 1'b0;
		rd          = 32'h0000_0000;

		d             = q;
		d.wake_int    = 1'b0;
		d.waitrequest = 1'b1;

		// Divider restarts as the reset pin rises, so two ticks mean two full cycles
		mc_tick  = (q.mc_cnt == rbpm_pkg::MC_LAST);
		d.mc_cnt = (mc_tick || (pin_lvl.rst_pin && !q.pin_prev)) ? 4'h0 : q.mc_cnt + 4'h1;

		// Count whole machine cycles of reset-high; the rising clock never counts
		d.pin_prev = pin_lvl.rst_pin;
		if (!pin_lvl.rst_pin) begin
			d.hold_mc = 2'h0;
		end else if (mc_tick && q.pin_prev && q.hold_mc != rbpm_pkg::RESET_MIN_MC) begin
			d.hold_mc = q.hold_mc + 2'h1;
		end
		// A shorter pulse is ignored, as the pin has not qualified
		reset_ok    = pin_lvl.rst_pin && (q.hold_mc == rbpm_pkg::RESET_MIN_MC);
		release_now = !pin_lvl.rst_pin && q.pin_prev
			&& (q.hold_mc == rbpm_pkg::RESET_MIN_MC);
		straps_low  = !pin_lvl.p1_0 && !pin_lvl.p1_1;

		// Read mux; unmapped or unaligned reads return zero
		if (avs_req.address[1:0] == 2'b00) begin
			case (avs_req.address)
				rbpm_pkg::OFS_POWER_CONTROL: begin
					rd[rbpm_pkg::IDLE_POS] = q.idle_bit;
					rd[rbpm_pkg::PD_POS]   = q.power_down_bit;
					rd[rbpm_pkg::POF_POS]  = q.power_on_flag;
				end
				rbpm_pkg::OFS_FLASH_CONFIG: begin
					rd[rbpm_pkg::STRAP_POS]     = q.strap_boot_status;
					rd[rbpm_pkg::USER_VEC_POS]  = q.user_vec_n;
					rd[rbpm_pkg::FROM_ZERO_POS] = q.from_zero_n;
				end
				rbpm_pkg::OFS_BOOT_VECTOR: begin
					rd[7:0] = q.boot_vec;
				end
				rbpm_pkg::OFS_STATUS: begin
					rd[2:0]                      = 3'(q.mode);
					rd[rbpm_pkg::CORE_RST_POS]   = q.core_reset;
					rd[rbpm_pkg::ADDR_POS +: 16] = q.boot_addr;
				end
				default: begin
					rd = 32'h0000_0000;
				end
			endcase
		end

		// One wait cycle, then answer; write acts at the low-wait edge
		if ((avs_req.read || avs_req.write) && q.waitrequest) begin
			d.waitrequest = 1'b0;
			d.readdata    = avs_req.read ? rd : 32'h0000_0000;
		end
		wr_hit = avs_req.write && !q.waitrequest && avs_req.byteenable[0]
			&& (avs_req.address[1:0] == 2'b00);
		if (wr_hit) begin
			case (avs_req.address)
				rbpm_pkg::OFS_POWER_CONTROL: begin
					d.idle_bit       = avs_req.writedata[rbpm_pkg::IDLE_POS];
					d.power_down_bit = avs_req.writedata[rbpm_pkg::PD_POS];
					// Software may only clear the flag, never set it
					d.power_on_flag  = q.power_on_flag
						& avs_req.writedata[rbpm_pkg::POF_POS];
				end
				rbpm_pkg::OFS_FLASH_CONFIG: begin
					d.user_vec_n  = avs_req.writedata[rbpm_pkg::USER_VEC_POS];
					d.from_zero_n = avs_req.writedata[rbpm_pkg::FROM_ZERO_POS];
				end
				rbpm_pkg::OFS_BOOT_VECTOR: begin
					d.boot_vec = avs_req.writedata[7:0];
				end
				default: begin
					d.boot_vec = q.boot_vec;
				end
			endcase
		end

		// Enabled external level interrupts only
		wake_low = (!pin_lvl.int0_n && int0_enable) || (!pin_lvl.int1_n && int1_enable);

		// Mode sequencing
		case (q.mode)
			rbpm_pkg::MODE_RESET: begin
				// Strobes weakly high; ports pulled only on power-up
				d.core_reset  = 1'b1;
				d.cpu_run     = 1'b0;
				d.clock_run   = 1'b1;
				d.ale         = 1'b1;
				d.program_store_strobe_n_n      = 1'b1;
				d.strobe_weak = 1'b1;
				d.port_pull   = q.por_seq;
				if (release_now) begin
					d.mode              = rbpm_pkg::MODE_RUN;
					d.core_reset        = 1'b0;
					d.cpu_run           = 1'b1;
					d.strobe_weak       = 1'b0;
					d.port_pull         = 1'b0;
					d.por_seq           = 1'b0;
					d.strap_boot_status = straps_low;
					d.boot_addr         = pick_boot(pin_lvl.ea_n, straps_low,
						q.user_vec_n, q.from_zero_n, q.boot_vec);
				end
			end
			rbpm_pkg::MODE_RUN: begin
				// Strobes follow the core while running
				d.ale     = core_ale;
				d.program_store_strobe_n_n  = core_program_store_strobe_n_n;
				d.cpu_run = 1'b1;
				// Power-down wins when both bits are written together
				if (d.power_down_bit) begin
					d.mode      = rbpm_pkg::MODE_PDOWN;
					d.cpu_run   = 1'b0;
					d.clock_run = 1'b0;
					d.ale       = 1'b0;
					d.program_store_strobe_n_n    = 1'b0;
					d.low_cnt   = 11'h000;
				end else if (d.idle_bit) begin
					d.mode    = rbpm_pkg::MODE_IDLE;
					d.cpu_run = 1'b0;
					d.ale     = 1'b1;
					d.program_store_strobe_n_n  = 1'b1;
				end
			end
			rbpm_pkg::MODE_IDLE: begin
				// Clock and peripherals run; only the PC stops
				d.clock_run = 1'b1;
				d.ale       = 1'b1;
				d.program_store_strobe_n_n    = 1'b1;
				if (irq_start) begin
					d.idle_bit = 1'b0;
					d.mode     = rbpm_pkg::MODE_RUN;
					d.cpu_run  = 1'b1;
				end
			end
			rbpm_pkg::MODE_PDOWN: begin
				// Count how long an enabled pin has been held low
				d.ale    = 1'b0;
				d.program_store_strobe_n_n = 1'b0;
				if (!wake_low) begin
					d.low_cnt = 11'h000;
				end else if (q.low_cnt == rbpm_pkg::WAKE_LOW_CLOCKS - 11'h001) begin
					// Interrupt start: clock back, bit cleared, wait for pin high
					d.power_down_bit = 1'b0;
					d.clock_run      = 1'b1;
					d.mode           = rbpm_pkg::MODE_WAKE;
					d.wake_src       = pin_lvl.int0_n && int1_enable;
				end else begin
					d.low_cnt = q.low_cnt + 11'h001;
				end
			end
			rbpm_pkg::MODE_WAKE: begin
				// Service starts only once the waking pin is back high
				d.ale    = 1'b0;
				d.program_store_strobe_n_n = 1'b0;
				if (q.wake_src ? pin_lvl.int1_n : pin_lvl.int0_n) begin
					d.wake_int = 1'b1;
					d.mode     = rbpm_pkg::MODE_RUN;
					d.cpu_run  = 1'b1;
				end
			end
			default: begin
				d.mode = rbpm_pkg::MODE_RESET;
			end
		endcase

		// A qualified reset overrides every mode and clears both requests
		if (reset_ok) begin
			d.mode           = rbpm_pkg::MODE_RESET;
			d.idle_bit       = 1'b0;
			d.power_down_bit = 1'b0;
			d.core_reset     = 1'b1;
			d.cpu_run        = 1'b0;
			d.clock_run      = 1'b1;
			d.ale            = 1'b1;
			d.program_store_strobe_n_n         = 1'b1;
			d.strobe_weak    = 1'b1;
			d.port_pull      = q.por_seq;
			d.low_cnt        = 11'h000;
		end
	end

	// State register; rst is the power-on reset of this block.
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= RESET_STATE;
		end else begin
			q <= d;
		end
	end

	// Every output straight from the state register
	assign avs_readdata           = q.readdata;
	assign avs_waitrequest        = q.waitrequest;
	assign core_reset             = q.core_reset;
	assign cpu_run                = q.cpu_run;
	assign clock_run              = q.clock_run;
	assign boot_address           = q.boot_addr;
	assign address_latch_strobe   = q.ale;
	assign program_store_strobe_n = q.program_store_strobe_n_n;
	assign strobe_weak            = q.strobe_weak;
	assign port_pull_high         = q.port_pull;
	assign wake_int               = q.wake_int;
	assign wake_source            = q.wake_src;

endmodule : reset_boot_power_modes

// [dv/reset_boot_power_modes_properties.sv]
`timescale 1ns/10ps
// Watches the sequencer ports; counters rebuild pin history
module rbpm_checker (
	input wire logic               clk,
	input wire logic               rst,
	input wire rbpm_pkg::avs_req_t avs_req,
	input wire logic               avs_waitrequest,
	input wire rbpm_pkg::pins_t    pins,
	input wire logic               irq_start,
	input wire logic               int0_enable,
	input wire logic               int1_enable,
	input wire logic               core_reset,
	input wire logic               cpu_run,
	input wire logic               clock_run,
	input wire logic [15:0]        boot_address,
	input wire logic               address_latch_strobe,
	input wire logic               program_store_strobe_n,
	input wire logic               strobe_weak,
	input wire logic               wake_int
);
	logic [10:0] low_q; // Run of enabled wake pin low, raw
	logic [5:0]  hi_q;  // Last run of reset pin high, kept after fall
	logic        pin_q; // Reset pin one clock ago
	logic        lo_now; // Some enabled wake pin low now
	assign lo_now = (!pins.int0_n && int0_enable) || (!pins.int1_n && int1_enable);
	// Raw counts; filter delay only lengthens them, so bounds stay safe
	always_ff @(posedge clk) begin
		if (rst) begin
			low_q <= '0;
			hi_q  <= '0;
			pin_q <= 1'b0;
		end else begin
			pin_q <= pins.rst_pin;
			low_q <= !lo_now ? 11'h000 : (low_q == 11'h7FF ? low_q : low_q + 11'h001);
			if (pins.rst_pin) begin
				hi_q <= !pin_q ? 6'h01 : (hi_q == 6'h3F ? hi_q : hi_q + 6'h01);
			end
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	weak_strobe_a: assert property (core_reset |-> address_latch_strobe && program_store_strobe_n && strobe_weak)
		else $error("strobes not weak high in reset");
	pdown_state_a: assert property (!clock_run |-> !cpu_run && !address_latch_strobe && !program_store_strobe_n)
		else $error("power-down outputs wrong");
	bus_answer_a: assert property ((avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	bus_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	wake_pulse_a: assert property (wake_int |=> !wake_int && cpu_run)
		else $error("wake pulse wrong");
	wake_held_a: assert property ($rose(clock_run) && !core_reset |-> low_q >= 11'd1024)
		else $error("woke without long low");
	idle_leave_a: assert property (!cpu_run && clock_run && !core_reset && program_store_strobe_n && irq_start
		|=> cpu_run)
		else $error("idle not left");
	reset_qual_a: assert property ($fell(core_reset) |-> hi_q >= 6'd24)
		else $error("reset released on short pulse");
	reset_force_a: assert property (hi_q == 6'd36 && pins.rst_pin |-> core_reset)
		else $error("long reset pin ignored");
	ext_zero_a: assert property ($fell(core_reset) && !pins.ea_n |=> boot_address == 16'h0000)
		else $error("external code boot not zero");
endmodule : rbpm_checker
bind reset_boot_power_modes rbpm_checker chk (.clk(clk), .rst(rst), .avs_req(avs_req),
	.avs_waitrequest(avs_waitrequest), .pins(pins), .irq_start(irq_start), .int0_enable(int0_enable),
	.int1_enable(int1_enable), .core_reset(core_reset), .cpu_run(cpu_run), .clock_run(clock_run),
	.boot_address(boot_address), .address_latch_strobe(address_latch_strobe),
	.program_store_strobe_n(program_store_strobe_n), .strobe_weak(strobe_weak), .wake_int(wake_int));

// [dv/pin_partner.sv]
`timescale 1ns/10ps
// Far side: reset circuit, strap pins and wake pins
module pin_partner (
	input  wire logic            clk,
	output      rbpm_pkg::pins_t pins
);
	// Reset low, straps pulled high, wake pins released high
	initial pins = 6'b111110;
	// Straps settle before the pulse and stay well past its fall
	task automatic pin_reset(input int n, input logic [2:0] sel);
		pins.ea_n <= sel[2];
		pins.p1_1 <= sel[1];
		pins.p1_0 <= sel[0];
		@(posedge clk);
		pins.rst_pin <= 1'b1;
		repeat (n) @(posedge clk);
		pins.rst_pin <= 1'b0;
		repeat (8) @(posedge clk);
		pins.p1_1 <= 1'b1; // Pull-up wins once released
		pins.p1_0 <= 1'b1;
	endtask : pin_reset
	// Wake pin held at a level for n clocks
	task automatic drive_int(input logic which, input logic lvl, input int n);
		if (which) pins.int1_n <= lvl;
		else pins.int0_n <= lvl;
		repeat (n) @(posedge clk);
	endtask : drive_int
endmodule : pin_partner

// [dv/reset_boot_power_modes_test.sv]
`timescale 1ns/10ps
module reset_boot_power_modes_test;
	localparam logic [15:0] BOOT_DEF = 16'h2000; // Arbitrary default vector
	logic clk, rst, irq_start, int0_enable, int1_enable, core_ale, core_program_store_strobe_n_n;
	logic core_reset, cpu_run, clock_run, ale, program_store_strobe_n_n, strobe_weak, port_pull_high, wake_int, wake_source;
	logic [31:0] rdata, q;
	logic        waitreq;
	logic [15:0] boot_address;
	logic [12:0] cases [6]; // {ea_n, p1_1, p1_0, from_zero, user_vec, vector}
	logic [12:0] c;
	rbpm_pkg::avs_req_t avs_req;
	rbpm_pkg::pins_t    pins;
	int err_count = 0, check_count = 0, cycle_count = 0;
	pin_partner pp (.clk(clk), .pins(pins));
	reset_boot_power_modes #(.LARGE_PART(1'b1), .DEFAULT_BOOT_ADDR(BOOT_DEF)) uut (.clk(clk), .rst(rst),
		.avs_req(avs_req), .avs_readdata(rdata), .avs_waitrequest(waitreq), .pins(pins), .core_ale(core_ale),
		.core_program_store_strobe_n_n(core_program_store_strobe_n_n), .irq_start(irq_start), .int0_enable(int0_enable), .int1_enable(int1_enable),
		.core_reset(core_reset), .cpu_run(cpu_run), .clock_run(clock_run), .boot_address(boot_address),
		.address_latch_strobe(ale), .program_store_strobe_n(program_store_strobe_n_n), .strobe_weak(strobe_weak),
		.port_pull_high(port_pull_high), .wake_int(wake_int), .wake_source(wake_source));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	// Hang guard, well above the expected few thousand clocks
	always @(posedge clk) begin
		cycle_count++;
		if (cycle_count == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One bus transfer; held until waitrequest sampled low, then one quiet edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_req.address <= a;
		avs_req.write <= wr;
		avs_req.read <= !wr;
		avs_req.writedata <= d;
		do @(posedge clk); while (waitreq !== 1'b0);
		q = rdata;
		avs_req.read <= 1'b0;
		avs_req.write <= 1'b0;
		@(posedge clk);
	endtask : bus
	function automatic logic [15:0] boot_exp(input logic [12:0] k);
		if (!k[12]) return 16'h0000;
		if (k[11:10] != 2'b00 && !k[9]) return 16'h0000;
		return k[8] ? BOOT_DEF : ({k[7:0], 8'h00} & rbpm_pkg::LARGE_MASK);
	endfunction : boot_exp
	// Waits a bounded time for the core to leave reset
	task automatic released();
		repeat (60) if (core_reset === 1'b1) @(posedge clk);
		repeat (2) @(posedge clk);
		check("core_reset", 32'(core_reset), 32'h0);
	endtask : released
	initial begin
		rst = 1'b1;
		avs_req = '0;
		avs_req.byteenable = 4'hF;
		core_ale = 1'b1;
		core_program_store_strobe_n_n = 1'b1;
		irq_start = 1'b0;
		int0_enable = 1'b1;
		int1_enable = 1'b0;
		cases = '{13'h00FF, 13'h1300, 13'h12FF, 13'h1CFF, 13'h165A, 13'h1B00};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("power-up pins", 32'({core_reset, strobe_weak, port_pull_high, ale, program_store_strobe_n_n}), 32'h1F);
		bus(1'b0, rbpm_pkg::OFS_POWER_CONTROL, 32'h0);
		check("power_on_flag", 32'(q[4]), 32'h1);
		bus(1'b0, rbpm_pkg::OFS_FLASH_CONFIG, 32'h0);
		check("boot controls", 32'(q[3:2]), 32'h3);
		bus(1'b1, 4'h2, 32'hFFFFFFFF);
		bus(1'b0, 4'h2, 32'h0);
		check("unmapped", q, 32'h0);
		$display("test power-up done");
		// Every path of the boot choice
		for (int i = 0; i < 6; i++) begin
			c = cases[i];
			bus(1'b1, rbpm_pkg::OFS_FLASH_CONFIG, {28'h0, c[9], c[8], 2'b00});
			bus(1'b1, rbpm_pkg::OFS_BOOT_VECTOR, {24'h0, c[7:0]});
			pp.pin_reset(40, c[12:10]);
			released();
			check("boot_address", 32'(boot_address), 32'(boot_exp(c)));
			bus(1'b0, rbpm_pkg::OFS_FLASH_CONFIG, 32'h0);
			check("strap status", 32'(q[0]), 32'(c[11:10] == 2'b00));
		end
		check("pull after pin reset", 32'(port_pull_high), 32'h0);
		bus(1'b0, rbpm_pkg::OFS_POWER_CONTROL, 32'h0);
		check("flag kept", 32'(q[4]), 32'h1);
		pp.pin_reset(12, 3'b111);
		repeat (10) @(posedge clk);
		check("short pulse", 32'({core_reset, boot_address}), 32'(BOOT_DEF));
		$display("test boot done");
		// Idle entry and interrupt exit
		bus(1'b1, rbpm_pkg::OFS_POWER_CONTROL, 32'h11);
		repeat (2) @(posedge clk);
		check("idle outputs", 32'({cpu_run, clock_run, ale, program_store_strobe_n_n}), 32'h7);
		irq_start <= 1'b1;
		@(posedge clk);
		irq_start <= 1'b0;
		repeat (2) @(posedge clk);
		check("idle exit", 32'(cpu_run), 32'h1);
		bus(1'b0, rbpm_pkg::OFS_POWER_CONTROL, 32'h0);
		check("idle bit", 32'(q[1:0]), 32'h0);
		$display("test idle done");
		// Power-down: disabled pin, short pulse, then a real wake
		bus(1'b1, rbpm_pkg::OFS_POWER_CONTROL, 32'h12);
		repeat (2) @(posedge clk);
		check("pdown outputs", 32'({cpu_run, clock_run, ale, program_store_strobe_n_n}), 32'h0);
		pp.drive_int(1'b1, 1'b0, 1100);
		pp.drive_int(1'b1, 1'b1, 0);
		pp.drive_int(1'b0, 1'b0, 500);
		pp.drive_int(1'b0, 1'b1, 20);
		check("no early wake", 32'(clock_run), 32'h0);
		pp.drive_int(1'b0, 1'b0, 1100);
		check("clock restart", 32'({clock_run, cpu_run, wake_int}), 32'h4);
		pp.drive_int(1'b0, 1'b1, 0);
		repeat (20) if (wake_int !== 1'b1) @(posedge clk);
		check("wake pulse", 32'({wake_int, wake_source}), 32'h2);
		bus(1'b0, rbpm_pkg::OFS_POWER_CONTROL, 32'h0);
		check("pd bit", 32'({cpu_run, q[1]}), 32'h2);
		bus(1'b0, rbpm_pkg::OFS_STATUS, 32'h0);
		check("status", q, {BOOT_DEF, 16'h0001});
		$display("test power-down done");
		// Reset out of idle, then flag clear
		bus(1'b1, rbpm_pkg::OFS_POWER_CONTROL, 32'h11);
		pp.pin_reset(40, 3'b100);
		released();
		bus(1'b0, rbpm_pkg::OFS_POWER_CONTROL, 32'h0);
		check("reset from idle", 32'({cpu_run, q[4], q[1:0]}), 32'hC);
		bus(1'b1, rbpm_pkg::OFS_POWER_CONTROL, 32'h0);
		bus(1'b0, rbpm_pkg::OFS_POWER_CONTROL, 32'h0);
		check("flag cleared", 32'(q[4]), 32'h0);
		$display("test reset done");
		give_verdict();
	end
endmodule : reset_boot_power_modes_test
